// ### include/tsd_pkg.sv
/*
 * Constants for the tile status and debug register bank: register
 * numbers, field positions, reset values and debug cause codes.
 * Assumes register numbers arrive already stripped of the resource
 * type byte by the core's status-register instruction decode.
 */
package tsd_pkg;

    localparam int DATA_W = 32;
    localparam int NUM_W  = 8;
    localparam int CNT_W  = 16;
    localparam int NOSC   = 4;

    // register numbers
    localparam logic [7:0] REG_BOOT_STATUS  = 8'h03;
    localparam logic [7:0] REG_SECURITY     = 8'h05;
    localparam logic [7:0] REG_OSC_CTRL     = 8'h06;
    localparam logic [7:0] REG_TILE_CELL    = 8'h07;
    localparam logic [7:0] REG_TILE_WIRE    = 8'h08;
    localparam logic [7:0] REG_PERIPH_CELL  = 8'h09;
    localparam logic [7:0] REG_PERIPH_WIRE  = 8'h0A;
    localparam logic [7:0] REG_DBG_SSW      = 8'h10;
    localparam logic [7:0] REG_DBG_SPC      = 8'h11;
    localparam logic [7:0] REG_DBG_SSP      = 8'h12;
    localparam logic [7:0] REG_DBG_CORE_SEL = 8'h13;
    localparam logic [7:0] REG_DBG_REG_SEL  = 8'h14;
    localparam logic [7:0] REG_DBG_CAUSE    = 8'h15;
    localparam logic [7:0] REG_DBG_INFO     = 8'h16;

    // boot status fields
    localparam int BOOT_TILE_LSB = 16;
    localparam int BOOT_OTP_BIT  = 8;

    // oscillator control fields
    localparam int OSC_TILE_EN_BIT   = 1;
    localparam int OSC_PERIPH_EN_BIT = 0;

    // debug cause and register select fields
    localparam int CAUSE_IDX_LSB  = 16;
    localparam int CAUSE_CORE_LSB = 8;
    localparam int CAUSE_CODE_W   = 3;
    localparam int IDX_W          = 2;
    localparam int REGSEL_W       = 5;

    // reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [2:0]  RST_CAUSE = 3'h0;

    typedef enum logic [2:0] {
        CAUSE_NONE  = 3'b000,
        CAUSE_HOST  = 3'b001,
        CAUSE_CALL  = 3'b010,
        CAUSE_IBRK  = 3'b011,
        CAUSE_DWTCH = 3'b100,
        CAUSE_RWTCH = 3'b101
    } tsd_cause_t;

    // lowest-numbered hit wins when several fire together
    function automatic logic [1:0] lowest_hit(input logic [3:0] hit);
        logic [1:0] idx;
        idx = 2'h0;
        if (hit[0])
            idx = 2'h0;
        else if (hit[1])
            idx = 2'h1;
        else if (hit[2])
            idx = 2'h2;
        else if (hit[3])
            idx = 2'h3;
        return idx;
    endfunction

    function automatic logic is_hw_cause(input logic [2:0] c);
        return (c == CAUSE_IBRK) || (c == CAUSE_DWTCH) || (c == CAUSE_RWTCH);
    endfunction

endpackage

// ### rtl/tsd_osc_counter.sv
/*
 * One ring oscillator counter. Counts every level change of the
 * oscillator output while enabled; holds its count otherwise.
 * Assumes the oscillator line is presented synchronous to CLK_SYS.
 */
`timescale 1ns/1ns
module tsd_osc_counter (
    input  wire logic                    clk,
    input  wire logic                    enable,
    input  wire logic                    osc_line,
    output logic [tsd_pkg::CNT_W-1:0]    count
);

    // power-up values only; system reset never touches them, and a known
    // start keeps the count from staying unknown forever
    logic                       prev_r = 1'b0;
    logic                       prev_nxt;
    logic [tsd_pkg::CNT_W-1:0]  count_r = 16'h0000;
    logic [tsd_pkg::CNT_W-1:0]  count_nxt;

    always_comb
    begin
        prev_nxt  = osc_line;
        count_nxt = count_r;
        if (enable && (osc_line != prev_r))
            count_nxt = count_r + 16'h0001;
    end

    // RULE10 no reset here
    // count survives system reset, so no reset term at all
    always_ff @(posedge clk)
    begin
        prev_r  <= prev_nxt;
        count_r <= count_nxt;
    end

    assign count = count_r;

endmodule

// ### rtl/tsd_status_bank.sv
/*
 * Processor status register bank of one tile: boot status, security
 * copy, four ring oscillator counters and the debug capture registers.
 * Assumes the local core issues one status access per request pulse,
 * and that the debug unit raises DBG_ENTRY for one cycle on entry.
 */
// Overview of operation
// RULE1 - boot status bits 23:16 give tile number
// RULE2 - boot status bit 8 shows OTP boot
// RULE3 - boot status bits 7:0 give sampled pins
// RULE4 - security register returns OTP security copy
// RULE5 - four oscillator counters, started via control register
// RULE6 - control bit1 tile, bit0 peripheral, reset 0
// RULE7 - software reads counters only when stopped
// RULE8 - oscillators asynchronous, usable as random source
// RULE9 - four counter registers, 16 bits, upper zero
// RULE10 - counters keep value through system reset
// RULE11 - debug entry captures status, pc, sp
// RULE12 - core select operand in bits 7:0
// RULE13 - register select operand in bits 4:0
// RULE14 - cause code bits 2:0, reset 0
// RULE15 - hit index bits 17:16, lowest wins
// RULE16 - causing core bits 15:8, else zero
// RULE17 - info holds address or resource id
// RULE18 - software builds resource id from number
// RULE19 - reserved bits read zero, writes ignored
`timescale 1ns/1ns
module tsd_status_bank (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    input  wire logic        PS_REQ,
    input  wire logic        PS_WR,
    input  wire logic [7:0]  PS_NUM,
    input  wire logic [31:0] PS_WDATA,
    input  wire logic        PS_DEBUG_MODE,
    input  wire logic [7:0]  TILE_NUM,
    input  wire logic        OTP_BOOT_EN,
    input  wire logic [7:0]  BOOT_SELECT_PINS,
    input  wire logic [31:0] OTP_SECURITY_WORD,
    input  wire logic [3:0]  OSC_LINE,
    input  wire logic        DBG_ENTRY,
    input  wire logic [2:0]  DBG_CAUSE,
    input  wire logic        DBG_CORE_VALID,
    input  wire logic [7:0]  DBG_CORE_NUM,
    input  wire logic [3:0]  DBG_HW_HIT,
    input  wire logic [31:0] DBG_EFF_ADDR,
    input  wire logic [31:0] DBG_RES_ID,
    input  wire logic [31:0] SAVED_STATUS_WORD,
    input  wire logic [31:0] SAVED_PROGRAM_COUNTER,
    input  wire logic [31:0] SAVED_STACK_POINTER,
    output logic [31:0]      PS_RDATA,
    output logic             PS_ACK,
    output logic             TILE_OSC_EN,
    output logic             PERIPH_OSC_EN,
    output logic [7:0]       DEBUG_READ_CORE_SEL,
    output logic [4:0]       DEBUG_READ_REG_SEL
);

    // access decode
    logic        rd_req;
    logic        wr_req;
    logic        dbg_wr;

    // control group
    logic        tile_en_r;
    logic        tile_en_nxt;
    logic        periph_en_r;
    logic        periph_en_nxt;
    logic [7:0]  boot_mode_r;
    logic [7:0]  boot_mode_nxt;

    // debug group
    logic [31:0] ssw_r;
    logic [31:0] ssw_nxt;
    logic [31:0] spc_r;
    logic [31:0] spc_nxt;
    logic [31:0] ssp_r;
    logic [31:0] ssp_nxt;
    logic [7:0]  core_sel_r;
    logic [7:0]  core_sel_nxt;
    logic [4:0]  reg_sel_r;
    logic [4:0]  reg_sel_nxt;
    logic [2:0]  cause_r;
    logic [2:0]  cause_nxt;
    logic [1:0]  hit_idx_r;
    logic [1:0]  hit_idx_nxt;
    logic [7:0]  cause_core_r;
    logic [7:0]  cause_core_nxt;
    logic [31:0] info_r;
    logic [31:0] info_nxt;

    // read port group
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] read_val;

    // oscillators
    logic [3:0]  osc_en;
    logic [15:0] osc_cnt [4];

    // RULE18 number already decoded
    // the core strips the resource type byte before presenting PS_NUM
    assign rd_req = PS_REQ && !PS_WR;
    assign wr_req = PS_REQ && PS_WR;
    // debug-only registers accept writes only in debug mode
    assign dbg_wr = wr_req && PS_DEBUG_MODE;

    // RULE5 two enable groups
    assign osc_en = {periph_en_r, periph_en_r, tile_en_r, tile_en_r};

    // RULE8 enable-gated counters
    // order: tile cell, tile wire, peripheral cell, peripheral wire
    for (genvar i = 0; i < tsd_pkg::NOSC; i++)
    begin : g_osc
        tsd_osc_counter u_cnt (
            .clk      (CLK_SYS),
            .enable   (osc_en[i]),
            .osc_line (OSC_LINE[i]),
            .count    (osc_cnt[i])
        );
    end

    //------------------------------------------------------------------
    // control group
    always_comb
    begin
        tile_en_nxt   = tile_en_r;
        periph_en_nxt = periph_en_r;
        boot_mode_nxt = boot_mode_r;
        // RULE6 oscillator enable write
        if (wr_req && (PS_NUM == tsd_pkg::REG_OSC_CTRL))
        begin
            tile_en_nxt   = PS_WDATA[tsd_pkg::OSC_TILE_EN_BIT];
            periph_en_nxt = PS_WDATA[tsd_pkg::OSC_PERIPH_EN_BIT];
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            tile_en_r   <= 1'b0;
            periph_en_r <= 1'b0;
        end
        else
        begin
            tile_en_r   <= tile_en_nxt;
            periph_en_r <= periph_en_nxt;
        end
    end

    // RULE3 strap sampling
    // pins are caught while reset is held, then frozen
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
            boot_mode_r <= BOOT_SELECT_PINS;
        else
            boot_mode_r <= boot_mode_nxt;
    end

    //------------------------------------------------------------------
    // debug group; capture beats a same-cycle software write
    always_comb
    begin
        ssw_nxt        = ssw_r;
        spc_nxt        = spc_r;
        ssp_nxt        = ssp_r;
        core_sel_nxt   = core_sel_r;
        reg_sel_nxt    = reg_sel_r;
        cause_nxt      = cause_r;
        hit_idx_nxt    = hit_idx_r;
        cause_core_nxt = cause_core_r;
        info_nxt       = info_r;
        if (dbg_wr)
        begin
            case (PS_NUM)
                tsd_pkg::REG_DBG_SPC:
                    spc_nxt = PS_WDATA;
                tsd_pkg::REG_DBG_SSP:
                    ssp_nxt = PS_WDATA;
                // RULE12 core select write
                tsd_pkg::REG_DBG_CORE_SEL:
                    core_sel_nxt = PS_WDATA[7:0];
                // RULE13 register select write
                tsd_pkg::REG_DBG_REG_SEL:
                    reg_sel_nxt = PS_WDATA[tsd_pkg::REGSEL_W-1:0];
                tsd_pkg::REG_DBG_CAUSE:
                begin
                    cause_nxt      = PS_WDATA[tsd_pkg::CAUSE_CODE_W-1:0];
                    cause_core_nxt = PS_WDATA[tsd_pkg::CAUSE_CORE_LSB +: 8];
                    hit_idx_nxt    = PS_WDATA[tsd_pkg::CAUSE_IDX_LSB +: tsd_pkg::IDX_W];
                end
                tsd_pkg::REG_DBG_INFO:
                    info_nxt = PS_WDATA;
                default:
                    ;
            endcase
        end
        if (DBG_ENTRY)
        begin
            // RULE11 capture saved state
            ssw_nxt = SAVED_STATUS_WORD;
            spc_nxt = SAVED_PROGRAM_COUNTER;
            ssp_nxt = SAVED_STACK_POINTER;
            // RULE14 cause code
            cause_nxt = DBG_CAUSE;
            // RULE15 lowest hit index
            hit_idx_nxt = tsd_pkg::is_hw_cause(DBG_CAUSE) ?
                          tsd_pkg::lowest_hit(DBG_HW_HIT) : 2'h0;
            // RULE16 causing core
            cause_core_nxt = DBG_CORE_VALID ? DBG_CORE_NUM : 8'h00;
            // RULE17 address or resource
            if (DBG_CAUSE == tsd_pkg::CAUSE_DWTCH)
                info_nxt = DBG_EFF_ADDR;
            else if (DBG_CAUSE == tsd_pkg::CAUSE_RWTCH)
                info_nxt = DBG_RES_ID;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            ssw_r        <= tsd_pkg::RST_WORD;
            spc_r        <= tsd_pkg::RST_WORD;
            ssp_r        <= tsd_pkg::RST_WORD;
            core_sel_r   <= 8'h00;
            reg_sel_r    <= 5'h00;
            // RULE14 cause resets zero
            cause_r      <= tsd_pkg::RST_CAUSE;
            hit_idx_r    <= 2'h0;
            cause_core_r <= 8'h00;
            info_r       <= tsd_pkg::RST_WORD;
        end
        else
        begin
            ssw_r        <= ssw_nxt;
            spc_r        <= spc_nxt;
            ssp_r        <= ssp_nxt;
            core_sel_r   <= core_sel_nxt;
            reg_sel_r    <= reg_sel_nxt;
            cause_r      <= cause_nxt;
            hit_idx_r    <= hit_idx_nxt;
            cause_core_r <= cause_core_nxt;
            info_r       <= info_nxt;
        end
    end

    //------------------------------------------------------------------
    // read mux
    always_comb
    begin
        // RULE19 reserved reads zero
        read_val = 32'h0000_0000;
        case (PS_NUM)
            tsd_pkg::REG_BOOT_STATUS:
            begin
                // RULE1 tile number field
                read_val[tsd_pkg::BOOT_TILE_LSB +: 8] = TILE_NUM;
                // RULE2 OTP boot flag
                read_val[tsd_pkg::BOOT_OTP_BIT] = OTP_BOOT_EN;
                // RULE3 sampled boot pins
                read_val[7:0] = boot_mode_r;
            end
            // RULE4 security copy
            tsd_pkg::REG_SECURITY:
                read_val = OTP_SECURITY_WORD;
            tsd_pkg::REG_OSC_CTRL:
            begin
                read_val[tsd_pkg::OSC_TILE_EN_BIT]   = tile_en_r;
                read_val[tsd_pkg::OSC_PERIPH_EN_BIT] = periph_en_r;
            end
            // RULE9 counter registers
            // RULE7 stop before reading
            // a running count may be caught mid-change; software must stop it
            tsd_pkg::REG_TILE_CELL:
                read_val[15:0] = osc_cnt[0];
            tsd_pkg::REG_TILE_WIRE:
                read_val[15:0] = osc_cnt[1];
            tsd_pkg::REG_PERIPH_CELL:
                read_val[15:0] = osc_cnt[2];
            tsd_pkg::REG_PERIPH_WIRE:
                read_val[15:0] = osc_cnt[3];
            tsd_pkg::REG_DBG_SSW:
                read_val = ssw_r;
            tsd_pkg::REG_DBG_SPC:
                read_val = spc_r;
            tsd_pkg::REG_DBG_SSP:
                read_val = ssp_r;
            tsd_pkg::REG_DBG_CORE_SEL:
                read_val[7:0] = core_sel_r;
            tsd_pkg::REG_DBG_REG_SEL:
                read_val[tsd_pkg::REGSEL_W-1:0] = reg_sel_r;
            tsd_pkg::REG_DBG_CAUSE:
            begin
                read_val[tsd_pkg::CAUSE_IDX_LSB +: tsd_pkg::IDX_W] = hit_idx_r;
                read_val[tsd_pkg::CAUSE_CORE_LSB +: 8]             = cause_core_r;
                read_val[tsd_pkg::CAUSE_CODE_W-1:0]                = cause_r;
            end
            tsd_pkg::REG_DBG_INFO:
                read_val = info_r;
            default:
                read_val = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        ack_nxt   = PS_REQ;
        rdata_nxt = rd_req ? read_val : rdata_r;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign PS_RDATA            = rdata_r;
    assign PS_ACK              = ack_r;
    assign TILE_OSC_EN         = tile_en_r;
    assign PERIPH_OSC_EN       = periph_en_r;
    assign DEBUG_READ_CORE_SEL = core_sel_r;
    assign DEBUG_READ_REG_SEL  = reg_sel_r;

    //------------------------------------------------------------------
    // checks
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    sequence s_read(logic [7:0] num);
        PS_REQ && !PS_WR && (PS_NUM == num);
    endsequence

    sequence s_write(logic [7:0] num);
        PS_REQ && PS_WR && (PS_NUM == num);
    endsequence

    AST_BOOT_TILE: assert property ( // RULE1
        s_read(tsd_pkg::REG_BOOT_STATUS) |=>
            PS_ACK && (PS_RDATA[23:16] == $past(TILE_NUM)))
        else $error("boot status tile number wrong");

    AST_BOOT_OTP: assert property ( // RULE2
        s_read(tsd_pkg::REG_BOOT_STATUS) |=>
            (PS_RDATA[8] == $past(OTP_BOOT_EN)) && (PS_RDATA[15:9] == 7'h00))
        else $error("boot status otp flag wrong");

    AST_BOOT_PINS: assert property ( // RULE3
        1'b1 |=> $stable(boot_mode_r))
        else $error("sampled boot pins changed after reset");

    AST_SEC_COPY: assert property ( // RULE4
        s_read(tsd_pkg::REG_SECURITY) |=> PS_RDATA == $past(OTP_SECURITY_WORD))
        else $error("security copy mismatch");

    AST_OSC_CTRL: assert property ( // RULE6
        s_write(tsd_pkg::REG_OSC_CTRL) |=>
            (TILE_OSC_EN == $past(PS_WDATA[1])) && (PERIPH_OSC_EN == $past(PS_WDATA[0])))
        else $error("oscillator enable not written");

    AST_OSC_HOLD: assert property ( // RULE5
        (!TILE_OSC_EN && !$past(TILE_OSC_EN)) [*2] |-> $stable(osc_cnt[0]))
        else $error("stopped oscillator counter moved");

    AST_OSC_UPPER: assert property ( // RULE9
        s_read(tsd_pkg::REG_PERIPH_WIRE) |=>
            (PS_RDATA[31:16] == 16'h0000) && (PS_RDATA[15:0] == $past(osc_cnt[3])))
        else $error("counter register upper bits not zero");

    AST_CAPTURE: assert property ( // RULE11
        DBG_ENTRY |=> (spc_r == $past(SAVED_PROGRAM_COUNTER))
            && (ssp_r == $past(SAVED_STACK_POINTER))
            && (ssw_r == $past(SAVED_STATUS_WORD)))
        else $error("debug entry capture wrong");

    AST_CORE_SEL: assert property ( // RULE12
        s_write(tsd_pkg::REG_DBG_CORE_SEL) ##0 PS_DEBUG_MODE ##0 !DBG_ENTRY |=>
            DEBUG_READ_CORE_SEL == $past(PS_WDATA[7:0]))
        else $error("core select not written");

    AST_REG_SEL_LOCK: assert property ( // RULE13
        s_write(tsd_pkg::REG_DBG_REG_SEL) ##0 !PS_DEBUG_MODE |=> $stable(DEBUG_READ_REG_SEL))
        else $error("register select written outside debug mode");

    AST_HIT_LOWEST: assert property ( // RULE15
        DBG_ENTRY && (DBG_CAUSE == tsd_pkg::CAUSE_IBRK) && (DBG_HW_HIT[1:0] == 2'b11)
            |=> hit_idx_r == 2'h0)
        else $error("breakpoint index not lowest");

    AST_CORE_ZERO: assert property ( // RULE16
        DBG_ENTRY && !DBG_CORE_VALID |=> (cause_core_r == 8'h00)
            && (cause_r == $past(DBG_CAUSE)))
        else $error("cause core field not cleared");

    AST_INFO_ADDR: assert property ( // RULE17
        DBG_ENTRY && (DBG_CAUSE == tsd_pkg::CAUSE_DWTCH) |=> info_r == $past(DBG_EFF_ADDR))
        else $error("watchpoint address not captured");

endmodule

// ### bench/tsd_core_model.sv
/*
 * Local core model: issues one status access at a time.
 * Assumes the bank acks each request exactly one cycle later.
 */
`timescale 1ns/1ns
module tsd_core_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdata,
    output logic             req,
    output logic             wr,
    output logic [7:0]       num,
    output logic [31:0]      wdata
);
    int idle = 0;
    int miss = 0;
    initial
    begin
        req = 1'b0;
        wr = 1'b0;
        num = 8'h00;
        wdata = 32'h0000_0000;
    end
    function automatic logic [31:0] res_id(input logic [7:0] n);
        return {16'h0000, n, 8'h0C};
    endfunction
    task automatic access(input logic w, input logic [7:0] n,
                          input logic [31:0] d, output logic [31:0] q);
        logic [31:0] id;
        id = res_id(n);
        repeat (idle + 1) @(posedge clk);
        #1;
        req = 1'b1;
        wr = w;
        num = id[15:8];
        wdata = d;
        @(posedge clk);
        #1;
        req = 1'b0;
        // released lines flip so stale values never look valid
        wr = ~w;
        num = ~num;
        wdata = ~wdata;
        if (ack !== 1'b1)
            miss++;
        q = rdata;
    endtask
endmodule

// ### bench/tb_top.sv
/*
 * Self-checking bench for the tile status and debug bank.
 * Assumes tsd_core_model drives the status bus; lines move 1 ns after edges.
 */
`timescale 1ns/1ns
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        dbg_mode = 1'b0;
    logic [7:0]  tile_num = 8'h5A;
    logic        otp_en = 1'b1;
    logic [7:0]  pins = 8'hC3;
    logic [31:0] otp_word = 32'h1234_ABCD;
    logic [3:0]  osc = 4'h0;
    logic        dbg_entry = 1'b0;
    logic [2:0]  cause = 3'h0;
    logic        cvalid = 1'b0;
    logic [7:0]  cnum = 8'h00;
    logic [3:0]  hit = 4'h0;
    logic [31:0] eaddr = 32'h0000_0000;
    logic [31:0] rid = 32'h0000_0000;
    logic [31:0] ssw = 32'h0000_0000;
    logic [31:0] saved_program_counter = 32'h0000_0000;
    logic [31:0] saved_stack_pointer = 32'h0000_0000;
    logic        req, wr, ack, tosc, posc;
    logic [7:0]  num, csel;
    logic [4:0]  rsel;
    logic [31:0] wdata, rdata, q;
    int          err_count = 0;
    int          checks_done = 0;
    int          cyc = 0;

    always #2 clk_sys = ~clk_sys;

    tsd_core_model core (.clk(clk_sys), .ack(ack), .rdata(rdata), .req(req),
        .wr(wr), .num(num), .wdata(wdata));
    tsd_status_bank uut (.CLK_SYS(clk_sys), .RST_B(rst_b), .PS_REQ(req), .PS_WR(wr),
        .PS_NUM(num), .PS_WDATA(wdata), .PS_DEBUG_MODE(dbg_mode), .TILE_NUM(tile_num),
        .OTP_BOOT_EN(otp_en), .BOOT_SELECT_PINS(pins), .OTP_SECURITY_WORD(otp_word),
        .OSC_LINE(osc), .DBG_ENTRY(dbg_entry), .DBG_CAUSE(cause),
        .DBG_CORE_VALID(cvalid), .DBG_CORE_NUM(cnum), .DBG_HW_HIT(hit),
        .DBG_EFF_ADDR(eaddr), .DBG_RES_ID(rid), .SAVED_STATUS_WORD(ssw),
        .SAVED_PROGRAM_COUNTER(saved_program_counter), .SAVED_STACK_POINTER(saved_stack_pointer), .PS_RDATA(rdata),
        .PS_ACK(ack), .TILE_OSC_EN(tosc), .PERIPH_OSC_EN(posc),
        .DEBUG_READ_CORE_SEL(csel), .DEBUG_READ_REG_SEL(rsel));

    task automatic complete_run;
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] n, output logic [31:0] v);
        core.access(1'b0, n, 32'h0000_0000, v);
    endtask

    task automatic wrr(input logic [7:0] n, input logic [31:0] d);
        core.access(1'b1, n, d, q);
    endtask

    task automatic t_boot;
        logic [31:0] v;
        rd(8'h03, v);
        chk(v, {8'h00, 8'h5A, 7'h00, 1'b1, 8'hC3});
        pins = 8'h3C;
        tile_num = 8'hA5;
        otp_en = 1'b0;
        wrr(8'h03, 32'hFFFF_FFFF);
        rd(8'h03, v);
        chk(v, {8'h00, 8'hA5, 7'h00, 1'b0, 8'hC3});
    endtask

    task automatic t_sec;
        logic [31:0] v;
        wrr(8'h05, 32'hFFFF_FFFF);
        rd(8'h05, v);
        chk(v, 32'h1234_ABCD);
    endtask

    task automatic t_osc;
        logic [31:0] v, w;
        logic [31:0] base [4];
        int n;
        for (n = 0; n < 4; n++)
            rd(8'h07 + n[7:0], base[n]);
        rd(8'h06, v);
        chk(v, 32'h0000_0000);
        wrr(8'h06, 32'hFFFF_FFFE);
        rd(8'h06, v);
        chk(v, 32'h0000_0002);
        chk({30'h0, tosc, posc}, 32'h0000_0002);
        wrr(8'h06, 32'h0000_0001);
        chk({30'h0, tosc, posc}, 32'h0000_0001);
        repeat (5)
        begin
            @(posedge clk_sys);
            #1;
            osc = ~osc;
        end
        wrr(8'h06, 32'h0000_0000);
        for (n = 7; n <= 10; n++)
        begin
            rd(n[7:0], v);
            chk({16'h0000, v[31:16]}, 32'h0000_0000);
            rd(n[7:0], w);
            chk(w, v);
            chk({16'h0000, v[15:0] - base[n-7][15:0]}, (n >= 9) ? 32'h5 : 32'h0);
        end
        rd(8'h09, v);
        @(posedge clk_sys);
        #1;
        rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        rd(8'h09, w);
        chk(w, v);
        chk({30'h0, tosc, posc}, 32'h0000_0000);
    endtask

    task automatic t_capture;
        logic [31:0] v, info, exp_cause;
        int c;
        info = 32'h0000_0000;
        for (c = 1; c <= 5; c++)
        begin
            cause = c[2:0];
            cvalid = c[0];
            cnum = 8'h20 + c[7:0];
            hit = c[0] ? 4'b1011 : 4'b1010;
            eaddr = 32'hA000_0000 + c;
            rid = 32'hB000_0000 + c;
            ssw = 32'h1000_0000 + c;
            saved_program_counter = 32'h2000_0000 + c;
            saved_stack_pointer = 32'h3000_0000 + c;
            dbg_entry = 1'b1;
            @(posedge clk_sys);
            #1;
            dbg_entry = 1'b0;
            if (c == 4)
                info = eaddr;
            if (c == 5)
                info = rid;
            rd(8'h10, v);
            chk(v, ssw);
            rd(8'h11, v);
            chk(v, saved_program_counter);
            rd(8'h12, v);
            chk(v, saved_stack_pointer);
            exp_cause = {14'h0, (c >= 3 && !c[0]) ? 2'h1 : 2'h0, c[0] ? cnum : 8'h00,
                5'h00, c[2:0]};
            rd(8'h15, v);
            chk(v, exp_cause);
            rd(8'h16, v);
            chk(v, info);
        end
    endtask

    task automatic t_dbg_regs;
        logic [7:0]  nums [6] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
        logic [31:0] msk [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_00FF,
            32'h0000_001F, 32'h0003_FF07, 32'hFFFF_FFFF};
        logic [31:0] v, old;
        int i;
        for (i = 0; i < 6; i++)
        begin
            rd(nums[i], old);
            wrr(nums[i], 32'hFFFF_FFFF);
            rd(nums[i], v);
            chk(v, old);
        end
        dbg_mode = 1'b1;
        core.idle = 2;
        for (i = 0; i < 6; i++)
        begin
            wrr(nums[i], 32'hFFFF_FFFF);
            rd(nums[i], v);
            chk(v, msk[i]);
        end
        chk({24'h0, csel}, 32'h0000_00FF);
        chk({27'h0, rsel}, 32'h0000_001F);
        wrr(8'h10, 32'h0000_0000);
        rd(8'h10, v);
        chk(v, ssw);
        wrr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, v);
        chk(v, 32'h0000_0000);
    endtask

    // hang guard, well above the few hundred cycles needed
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            complete_run;
        end
    end

    initial
    begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        t_boot;
        t_sec;
        t_osc;
        t_capture;
        t_dbg_regs;
        chk(32'(core.miss), 32'h0000_0000);
        complete_run;
    end
endmodule
